/* File: design/rxmf_defs.svh */
// Register offsets, field positions, reset values and timing counts of the matched filter block
`ifndef RXMF_DEFS_SVH
`define RXMF_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets, configuration set A and set B
// ---------------------------------------------------------------
`define RXMF_ADC_RATE_DIV_A   8'h6D
`define RXMF_MF_SCALE_DLY_A   8'h6F
`define RXMF_MF_DECIM_A       8'h70
`define RXMF_RUN_THR_A        8'h71
`define RXMF_WAKE_THR_A       8'h72
`define RXMF_NOISE_CFG_A      8'h81
`define RXMF_ADC_RATE_DIV_B   8'h8D
`define RXMF_MF_SCALE_DLY_B   8'h8F
`define RXMF_MF_DECIM_B       8'h90
`define RXMF_RUN_THR_B        8'h91
`define RXMF_WAKE_THR_B       8'h92
`define RXMF_NOISE_CFG_B      8'hA1
// Own registers: low threshold, control, noise threshold, status, quality
`define RXMF_LOW_THR_A        8'hB6
`define RXMF_LOW_THR_B        8'hB7
`define RXMF_CTRL             8'hC0
`define RXMF_NOISE_THR_A      8'hC1
`define RXMF_NOISE_THR_B      8'hC2
`define RXMF_STATUS           8'hC4
`define RXMF_QUALITY          8'hC5

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define RXMF_DLY_LSB          0
`define RXMF_SCA_LSB          3
`define RXMF_MODE_LSB         4
`define RXMF_CNT_LSB          6
`define RXMF_RDSRC_BIT        7
`define RXMF_CTRL_ASK_BIT     0
`define RXMF_CTRL_INV_BIT     1
`define RXMF_CTRL_WAKE_BIT    2
`define RXMF_CTRL_SETB_BIT    3
`define RXMF_CTRL_PRESL_BIT   4
`define RXMF_CTRL_EN_BIT      5
`define RXMF_REG_RESET        8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RXMF_SYNC_STAGES      2

`endif

/* File: design/rxmf_pkg.sv */
// Types shared by the matched filter and signal detector block
package rxmf_pkg;
  typedef logic [7:0] rxmf_byte_t;
  typedef enum logic [3:0] {
    RXMF_SQUELCH = 4'h1,
    RXMF_NOISE   = 4'h2,
    RXMF_BOTH    = 4'h4,
    RXMF_GATED   = 4'h8
  } rxmf_mode_e;
endpackage

/* File: design/rxmf_top.sv */
// Matched data filter with signal and noise detection for a Manchester receiver
//
// What this block does
// - Input mux picks FSK demodulator samples or ASK RSSI samples by modulation type.
// - Optional pre-slicer stage can be switched in for ASK operation.
// - ADC sample strobe comes from system clock divided by divider value plus one.
// - CIC decimates samples by six-bit factor plus one.
// - CIC comb delay equals comb delay field plus one; software writes 110b.
// - CIC is followed by a differentiator; together a one-bit Manchester matched filter.
// - Filter outputs a quality value that grows with bit reliability.
// - Data polarity invert bit flips the recovered data.
// - Quality and noise measure are compared with separate thresholds.
// - Two-bit mode picks squelch, noise, both, or squelch plus gated noise.
// - In gated mode noise detect counts only while low threshold is exceeded.
// - Run mode uses the run threshold register level.
// - Wake-up operation uses the wake-up threshold register level.
// - Run and wake-up threshold registers hold a two-bit counter field; 00b disables it.
// - Readout source bit selects plain quality or quality zeroed unless the low threshold is exceeded.
// - Low threshold gates detection only in mode 11b; with readout source bit set it also gates quality readout.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "rxmf_defs.svh"

module rxmf_top
  import rxmf_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [7:0] FSK_SAMPLE,
  input  wire logic [7:0] ADC_SAMPLE,
  input  wire logic [7:0] FSK_NOISE,
  output logic            ADC_STROBE,
  output logic            DATA_OUT,
  output logic            DATA_VALID,
  output logic            SIG_DETECT,
  output logic            NOISE_OK,
  output logic            DETECT
);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  rxmf_byte_t div_r [2];
  rxmf_byte_t sdly_r [2];
  rxmf_byte_t dec_r [2];
  rxmf_byte_t run_r [2];
  rxmf_byte_t wake_r [2];
  rxmf_byte_t ncfg_r [2];
  rxmf_byte_t low_r [2];
  rxmf_byte_t nthr_r [2];
  rxmf_byte_t ctrl_r;

  // Register writes, one generate per configuration set
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_set
      localparam logic [7:0] OFS = (gs == 0) ? 8'h00 : 8'h20;
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          div_r[gs]  <= `RXMF_REG_RESET;
          sdly_r[gs] <= `RXMF_REG_RESET;
          dec_r[gs]  <= `RXMF_REG_RESET;
          run_r[gs]  <= `RXMF_REG_RESET;
          wake_r[gs] <= `RXMF_REG_RESET;
          ncfg_r[gs] <= `RXMF_REG_RESET;
          low_r[gs]  <= `RXMF_REG_RESET;
          nthr_r[gs] <= `RXMF_REG_RESET;
        end else if (WR) begin
          if (ADDR == 8'(`RXMF_ADC_RATE_DIV_A + OFS)) div_r[gs]  <= WDATA;
          if (ADDR == 8'(`RXMF_MF_SCALE_DLY_A + OFS)) sdly_r[gs] <= WDATA;
          if (ADDR == 8'(`RXMF_MF_DECIM_A + OFS))     dec_r[gs]  <= WDATA;
          if (ADDR == 8'(`RXMF_RUN_THR_A + OFS))      run_r[gs]  <= WDATA;
          if (ADDR == 8'(`RXMF_WAKE_THR_A + OFS))     wake_r[gs] <= WDATA;
          if (ADDR == 8'(`RXMF_NOISE_CFG_A + OFS))    ncfg_r[gs] <= WDATA;
          if (ADDR == 8'(`RXMF_LOW_THR_A + 8'(gs)))   low_r[gs]  <= WDATA;
          if (ADDR == 8'(`RXMF_NOISE_THR_A + 8'(gs))) nthr_r[gs] <= WDATA;
        end
      end
    end
  endgenerate

  // Control register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_r <= `RXMF_REG_RESET;
    end else if (WR && ADDR == `RXMF_CTRL) begin
      ctrl_r <= WDATA;
    end
  end

  // Active set and decoded controls
  logic       sel;
  logic       ask;
  logic       inv;
  logic       wake;
  logic       presl;
  logic       en;
  rxmf_byte_t div_s;
  logic [2:0] dly;
  logic [2:0] sca;
  logic [5:0] dec;
  rxmf_byte_t thr_reg;
  logic [1:0] mode_f;
  logic [5:0] low_thr;
  logic       rdsrc;
  assign sel     = ctrl_r[`RXMF_CTRL_SETB_BIT];
  assign ask     = ctrl_r[`RXMF_CTRL_ASK_BIT];
  assign inv     = ctrl_r[`RXMF_CTRL_INV_BIT];
  assign wake    = ctrl_r[`RXMF_CTRL_WAKE_BIT];
  assign presl   = ctrl_r[`RXMF_CTRL_PRESL_BIT];
  assign en      = ctrl_r[`RXMF_CTRL_EN_BIT];
  assign div_s   = div_r[sel];
  assign dly     = sdly_r[sel][`RXMF_DLY_LSB +: 3];
  assign sca     = sdly_r[sel][`RXMF_SCA_LSB +: 3];
  assign dec     = dec_r[sel][5:0];
  assign thr_reg = wake ? wake_r[sel] : run_r[sel];
  assign mode_f  = ncfg_r[sel][`RXMF_MODE_LSB +: 2];
  assign low_thr = low_r[sel][5:0];
  assign rdsrc   = low_r[sel][`RXMF_RDSRC_BIT];

  // ---------------------------------------------------------------
  // Sample input: synchronise pins, then select source
  // ---------------------------------------------------------------
  rxmf_byte_t fsk_s1_r;
  rxmf_byte_t fsk_s2_r;
  rxmf_byte_t adc_s1_r;
  rxmf_byte_t adc_s2_r;
  rxmf_byte_t nse_s1_r;
  rxmf_byte_t nse_s2_r;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      fsk_s1_r <= 8'h00;
      fsk_s2_r <= 8'h00;
      adc_s1_r <= 8'h00;
      adc_s2_r <= 8'h00;
      nse_s1_r <= 8'h00;
      nse_s2_r <= 8'h00;
    end else begin
      fsk_s1_r <= FSK_SAMPLE;
      fsk_s2_r <= fsk_s1_r;
      adc_s1_r <= ADC_SAMPLE;
      adc_s2_r <= adc_s1_r;
      nse_s1_r <= FSK_NOISE;
      nse_s2_r <= nse_s1_r;
    end
  end

  // Pre-slicer: clip ASK samples to a window around mid scale
  rxmf_byte_t ask_smp;
  rxmf_byte_t in_smp;
  always_comb begin
    ask_smp = adc_s2_r;
    if (presl && adc_s2_r > 8'hC0) ask_smp = 8'hC0;
    if (presl && adc_s2_r < 8'h40) ask_smp = 8'h40;
    in_smp = ask ? ask_smp : fsk_s2_r;
  end

  // ---------------------------------------------------------------
  // ADC sample rate divider
  // ---------------------------------------------------------------
  rxmf_byte_t div_cnt_r;
  logic       tick_r;
  always_ff @(posedge CLK) begin
    if (!RESETN || !en) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end else if (div_cnt_r >= div_s) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      tick_r    <= 1'b0;
    end
  end
  assign ADC_STROBE = tick_r;

  // ---------------------------------------------------------------
  // CIC integrator, decimator and comb with delay up to eight
  // ---------------------------------------------------------------
  logic [19:0] integ_r;
  logic [19:0] comb_r [8];
  logic [5:0]  dcnt_r;
  logic        dtick_r;
  logic [19:0] scaled;
  assign scaled = 20'({12'h000, in_smp} >> sca);                 // 000b leaves full scale
  always_ff @(posedge CLK) begin
    if (!RESETN || !en) begin
      integ_r <= 20'h00000;
      dcnt_r  <= 6'h00;
      dtick_r <= 1'b0;
    end else begin
      dtick_r <= 1'b0;
      if (tick_r) begin
        integ_r <= integ_r + scaled;
        if (dcnt_r >= dec) begin
          dcnt_r  <= 6'h00;
          dtick_r <= 1'b1;
        end else begin
          dcnt_r <= dcnt_r + 6'h01;
        end
      end
    end
  end

  // Comb delay line, one stage per decimated sample
  genvar gd;
  generate
    for (gd = 0; gd < 8; gd++) begin : g_dly
      always_ff @(posedge CLK) begin
        if (!RESETN || !en) begin
          comb_r[gd] <= 20'h00000;
        end else if (dtick_r) begin
          comb_r[gd] <= (gd == 0) ? integ_r : comb_r[(gd == 0) ? 0 : gd - 1];
        end
      end
    end
  endgenerate

  // Comb output: delay of field plus one decimated samples
  logic [19:0] cic_out;
  assign cic_out = integ_r - comb_r[dly];

  // ---------------------------------------------------------------
  // Differentiator (DC canceller), data slice and quality
  // ---------------------------------------------------------------
  logic [19:0] cic_prev_r;
  logic [20:0] diff;
  logic [19:0] mag;
  logic [5:0]  quality;
  logic [5:0]  qual_r;
  logic        data_r;
  logic        dval_r;
  assign diff    = {1'b0, cic_out} - {1'b0, cic_prev_r};
  assign mag     = diff[20] ? 20'(~diff[19:0] + 20'h1) : diff[19:0];
  assign quality = (|mag[19:11]) ? 6'h3F : mag[10:5];
  always_ff @(posedge CLK) begin
    if (!RESETN || !en) begin
      cic_prev_r <= 20'h00000;
      qual_r     <= 6'h00;
      data_r     <= 1'b0;
      dval_r     <= 1'b0;
    end else begin
      dval_r <= dtick_r;
      if (dtick_r) begin
        cic_prev_r <= cic_out;
        qual_r     <= quality;
        data_r     <= diff[20] ~^ inv;
      end
    end
  end

  // ---------------------------------------------------------------
  // Signal and noise detectors with threshold counter
  // ---------------------------------------------------------------
  logic [1:0] cnt_r;
  logic       sig_raw;
  logic       low_hit;
  logic       nse_ok;
  logic       sig_det;
  rxmf_mode_e mode;
  assign sig_raw = qual_r > thr_reg[5:0];
  assign low_hit = qual_r > low_thr;
  assign nse_ok  = nse_s2_r < nthr_r[sel];
  assign sig_det = (thr_reg[7:6] == 2'b00) ? sig_raw : (cnt_r == thr_reg[7:6]);

  // Consecutive-hit counter; field 00b bypasses it
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cnt_r <= 2'b00;
    end else if (dval_r) begin
      if (!sig_raw || thr_reg[7:6] == 2'b00) cnt_r <= 2'b00;
      else if (cnt_r != thr_reg[7:6]) cnt_r <= cnt_r + 2'b01;
    end
  end

  // Mode decode
  always_comb begin
    case (mode_f)
      2'b00:   mode = RXMF_SQUELCH;
      2'b01:   mode = RXMF_NOISE;
      2'b10:   mode = RXMF_BOTH;
      default: mode = RXMF_GATED;
    endcase
  end

  // Combined detection decision
  logic det;
  always_comb begin
    case (mode)
      RXMF_SQUELCH: det = sig_det;
      RXMF_NOISE:   det = nse_ok;
      RXMF_BOTH:    det = sig_det && nse_ok;
      RXMF_GATED:   det = sig_det || (nse_ok && low_hit);
      default:      det = 1'b0;
    endcase
  end

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      DATA_OUT   <= 1'b0;
      DATA_VALID <= 1'b0;
      SIG_DETECT <= 1'b0;
      NOISE_OK   <= 1'b0;
      DETECT     <= 1'b0;
    end else begin
      DATA_OUT   <= data_r;
      DATA_VALID <= dval_r;
      SIG_DETECT <= sig_det;
      NOISE_OK   <= nse_ok;
      DETECT     <= det;
    end
  end

  // ---------------------------------------------------------------
  // Read port: configuration is write only except control; control, status and quality readable
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `RXMF_CTRL:    RDATA <= ctrl_r;
        `RXMF_QUALITY: RDATA <= {2'b00, rdsrc ? (low_hit ? qual_r : 6'h00) : qual_r};
        `RXMF_STATUS:  RDATA <= {4'h0, det, nse_ok, sig_det, data_r};
        default:       RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule

/* File: verification/rxmf_src_model.sv */
// Sample sources in front of the filter: demodulator output and RSSI converter
`timescale 1ns/1ns
module rxmf_src_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       adc_strobe,
  input  wire logic       ask_route,
  input  wire logic [7:0] noise_level,
  output logic      [7:0] fsk_sample,
  output logic      [7:0] ask_sample,
  output logic      [7:0] fsk_noise
);
  logic [3:0]  phase_r;
  logic [15:0] bits_r;
  logic [7:0]  level;
  // Manchester level: sixteen conversions a bit, polarity flips at mid bit
  assign level = (phase_r[3] ^ bits_r[0]) ? 8'hE0 : 8'h20;
  assign fsk_noise = noise_level;
  // Pseudo-random bit pattern, one bit per sixteen strobes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_r <= 4'h0;
      bits_r  <= 16'hACE1;
    end else if (adc_strobe) begin
      phase_r <= phase_r + 4'h1;
      bits_r  <= (phase_r == 4'hF) ? {bits_r[0] ^ bits_r[2] ^ bits_r[5], bits_r[15:1]} : bits_r;
    end
  end
  // Each strobe gives a new conversion; the idle source sits at mid scale
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ask_sample <= 8'h80;
      fsk_sample <= 8'h80;
    end else if (adc_strobe) begin
      ask_sample <= ask_route ? level : 8'h80;
      fsk_sample <= ask_route ? 8'h80 : level;
    end
  end
endmodule

/* File: verification/rxmf_top_sva.sv */
// Port checker of the matched filter and detector block
`timescale 1ns/1ns
module rxmf_top_sva
  import rxmf_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] FSK_SAMPLE,
  input wire logic [7:0] ADC_SAMPLE,
  input wire logic [7:0] FSK_NOISE,
  input wire logic       ADC_STROBE,
  input wire logic       DATA_OUT,
  input wire logic       DATA_VALID,
  input wire logic       SIG_DETECT,
  input wire logic       NOISE_OK,
  input wire logic       DETECT
);
  logic [7:0] dva_r, dvb_r, ctl_r;
  logic [1:0] mod_r;
  logic [8:0] gap_r;
  logic       seen_r;
  wire  [7:0] div_w = ctl_r[3] ? dvb_r : dva_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Shadow of divider, control and set A mode
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dva_r <= 8'h00;
      dvb_r <= 8'h00;
      ctl_r <= 8'h00;
      mod_r <= 2'h0;
    end else if (WR) begin
      dva_r <= (ADDR == 8'h6D) ? WDATA : dva_r;
      dvb_r <= (ADDR == 8'h8D) ? WDATA : dvb_r;
      ctl_r <= (ADDR == 8'hC0) ? WDATA : ctl_r;
      mod_r <= (ADDR == 8'h81) ? WDATA[5:4] : mod_r;
    end
  end
  // Clocks since the last strobe; any write re-arms the spacing check
  always_ff @(posedge CLK) begin
    gap_r  <= (!RESETN || WR || ADC_STROBE) ? 9'h001 : gap_r + {8'h00, gap_r != 9'h1FF};
    seen_r <= RESETN && !WR && (seen_r || ADC_STROBE);
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  strobe_period_a: assert property (ADC_STROBE && seen_r |-> gap_r == {1'b0, div_w} + 9'h001)
    else $error("strobe spacing not divider plus one");
  strobe_pulse_a: assert property (
    ADC_STROBE && div_w != 8'h00 && !WR |=> !ADC_STROBE)
    else $error("strobe longer than one clock");
  valid_pulse_a: assert property (
    DATA_VALID && div_w != 8'h00 && $past(div_w) != 8'h00 && $past(div_w, 2) != 8'h00 &&
    $past(div_w, 3) != 8'h00 |=> !DATA_VALID)
    else $error("valid longer than one clock");
  data_hold_a: assert property ($changed(DATA_OUT) |-> DATA_VALID)
    else $error("data changed without valid");
  status_read_a: assert property (
    $past(RD) && $past(ADDR) == 8'hC4 |->
    RDATA == {4'h0, DETECT, NOISE_OK, SIG_DETECT, DATA_OUT})
    else $error("status read differs from outputs");
  quality_range_a: assert property ($past(RD) && $past(ADDR) == 8'hC5 |-> RDATA[7:6] == 2'b00)
    else $error("quality wider than six bits");
  wo_zero_a: assert property (
    $past(RD) && $past(ADDR) inside {8'h6D, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h81} |-> RDATA == 8'h00)
    else $error("write-only register read not zero");
  squelch_only_a: assert property (
    mod_r == 2'h0 && $past(mod_r, 8) == 2'h0 && !ctl_r[3] && DETECT |->
    SIG_DETECT || $past(SIG_DETECT) || $past(SIG_DETECT, 2))
    else $error("detect without signal in squelch mode");
endmodule

bind rxmf_top rxmf_top_sva chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .FSK_SAMPLE(FSK_SAMPLE), .ADC_SAMPLE(ADC_SAMPLE),
  .FSK_NOISE(FSK_NOISE), .ADC_STROBE(ADC_STROBE), .DATA_OUT(DATA_OUT),
  .DATA_VALID(DATA_VALID), .SIG_DETECT(SIG_DETECT), .NOISE_OK(NOISE_OK), .DETECT(DETECT));

/* File: verification/tb_rx_matched_filter_signal_detect.sv */
// Self-checking bench of the matched filter and detector block
`timescale 1ns/1ns
`include "rxmf_defs.svh"
module tb_rx_matched_filter_signal_detect;
  import rxmf_pkg::*;
  logic        CLK, RESETN, WR, RD, ask_route, sd, nok, det;
  logic [7:0]  ADDR, WDATA, noise_lvl, d, dv, dc;
  logic [31:0] seed, ref0, cap1;
  int          err_total, check_count, cyc, n;
  wire logic       ADC_STROBE, DATA_OUT, DATA_VALID, SIG_DETECT, NOISE_OK, DETECT;
  wire logic [7:0] RDATA, FSK_SAMPLE, ADC_SAMPLE, FSK_NOISE;
  localparam logic [7:0] WO [13] = '{8'h6D, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h81, 8'h8D,
                                     8'h8F, 8'h90, 8'h91, 8'h92, 8'hA1, 8'h33};
  rxmf_top dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .FSK_SAMPLE(FSK_SAMPLE), .ADC_SAMPLE(ADC_SAMPLE), .FSK_NOISE(FSK_NOISE),
    .ADC_STROBE(ADC_STROBE), .DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID),
    .SIG_DETECT(SIG_DETECT), .NOISE_OK(NOISE_OK), .DETECT(DETECT));
  rxmf_src_model src (.clk(CLK), .resetn(RESETN), .adc_strobe(ADC_STROBE), .ask_route(ask_route),
    .noise_level(noise_lvl), .fsk_sample(FSK_SAMPLE), .ask_sample(ADC_SAMPLE), .fsk_noise(FSK_NOISE));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Combined decision of each detection mode
  function automatic logic exp_det(input logic [1:0] m, input logic s, input logic k, input logic g);
    return (m == 2'h0) ? s : (m == 2'h1) ? k : (m == 2'h2) ? (s && k) : (s || (k && g));
  endfunction
  task automatic test_done();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // Set A configuration, then enable
  task automatic setup(input logic [7:0] ctl, dv, dc, thr, wk, lo, input logic [1:0] m);
    wr(`RXMF_ADC_RATE_DIV_A, dv);
    wr(`RXMF_MF_SCALE_DLY_A, 8'h06);
    wr(`RXMF_MF_DECIM_A, dc);
    wr(`RXMF_RUN_THR_A, thr);
    wr(`RXMF_WAKE_THR_A, wk);
    wr(`RXMF_NOISE_CFG_A, {2'b00, m, 4'b0111});
    wr(`RXMF_NOISE_THR_A, 8'h80);
    wr(`RXMF_LOW_THR_A, lo);
    wr(`RXMF_CTRL, ctl | 8'h20);
  endtask
  // Clocks between strobes, or strobes between valids
  task automatic meas(input bit v, output int c);
    repeat (3) @(posedge CLK iff (v ? DATA_VALID : ADC_STROBE));
    c = 0;
    do begin
      @(posedge CLK);
      c += v ? int'(ADC_STROBE) : 1;
    end while ((v ? DATA_VALID : ADC_STROBE) !== 1'b1);
  endtask
  // One detection setting, watched over ten bits after settling
  task automatic run_case(input logic r, input logic [7:0] ctl, thr, wk, lo,
                          input logic [1:0] m, input logic hi);
    logic s, k, g;
    ask_route <= r;
    noise_lvl <= hi ? (8'hC0 | seed[7:0]) : {2'b00, seed[5:0]};
    seed = lfsr(seed);
    setup(ctl, 8'h00, 8'h00, thr, wk, lo, m);
    s = (r == ctl[0]) && ((ctl[2] ? wk[5:0] : thr[5:0]) == 6'h00);
    k = !hi;
    g = (r == ctl[0]) && (lo[5:0] == 6'h00);
    repeat (40) @(posedge CLK iff DATA_VALID);
    {sd, nok, det} = 3'b000;
    repeat (160) begin
      @(posedge CLK);
      {sd, nok, det} = {sd, nok, det} | {SIG_DETECT, NOISE_OK, DETECT};
    end
    rd(`RXMF_STATUS);
    chk8("sig_detect", {7'h00, s}, {7'h00, sd});
    chk8("noise_ok", {7'h00, k}, {7'h00, nok});
    chk8("detect", {7'h00, exp_det(m, s, k, g)}, {7'h00, det});
  endtask
  // Fresh reset, then thirty-two recovered bits
  task automatic capture(input logic [7:0] ctl, output logic [31:0] q);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    setup(ctl, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0);
    for (int i = 0; i < 32; i++) begin
      @(posedge CLK iff DATA_VALID);
      q[i] = DATA_OUT;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {RESETN, WR, RD, ADDR, WDATA} = '0;
    {ask_route, noise_lvl} = 9'h100;
    seed = 32'h86BD7245;
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    rd(`RXMF_CTRL);
    chk8("ctrl_reset", `RXMF_REG_RESET, d);
    foreach (WO[i]) begin
      wr(WO[i], seed[7:0]);
      seed = lfsr(seed);
      rd(WO[i]);
      chk8("write_only", 8'h00, d);
    end
    wr(`RXMF_MF_DECIM_B, 8'h00); // set B decimates by one in the strobe loop
    for (int i = 0; i < 4; i++) begin
      dv = (i == 0) ? 8'h00 : (i == 3) ? 8'hFF : {4'h0, seed[3:0]};
      dc = {6'h00, seed[5:4]};
      seed = lfsr(seed);
      wr(`RXMF_ADC_RATE_DIV_B, dv);
      setup(i[0] ? 8'h09 : 8'h01, i[0] ? 8'h00 : dv, dc, 8'h3F, 8'h3F, 8'h3F, 2'h0);
      meas(1'b0, n);
      chk8("strobe_gap", dv + 8'h01, 8'(n));
      meas(1'b1, n);
      chk8("decimation", i[0] ? 8'h01 : dc + 8'h01, 8'(n));
    end
    rd(`RXMF_CTRL);
    chk8("ctrl", 8'h29, d);
    run_case(1'b1, 8'h01, 8'h00, 8'h3F, 8'h3F, 2'h0, 1'b1);
    run_case(1'b0, 8'h01, 8'h00, 8'h3F, 8'h3F, 2'h0, 1'b1);
    run_case(1'b0, 8'h00, 8'h00, 8'h3F, 8'h3F, 2'h0, 1'b0);
    run_case(1'b1, 8'h05, 8'h3F, 8'hC0, 8'h3F, 2'h0, 1'b0);
    run_case(1'b1, 8'h01, 8'h3F, 8'h00, 8'h00, 2'h0, 1'b0);
    run_case(1'b1, 8'h01, 8'h3F, 8'h3F, 8'h3F, 2'h1, 1'b0);
    run_case(1'b1, 8'h01, 8'h3F, 8'h3F, 8'h3F, 2'h1, 1'b1);
    run_case(1'b1, 8'h01, 8'h00, 8'h3F, 8'h3F, 2'h2, 1'b0);
    run_case(1'b1, 8'h11, 8'h00, 8'h3F, 8'h3F, 2'h0, 1'b1);
    run_case(1'b1, 8'h01, 8'h3F, 8'h3F, 8'h00, 2'h3, 1'b0);
    run_case(1'b1, 8'h01, 8'h3F, 8'h3F, 8'hBF, 2'h3, 1'b0);
    rd(`RXMF_QUALITY);
    chk8("quality_low", 8'h00, d);
    wr(`RXMF_LOW_THR_A, 8'h3F);
    capture(8'h01, ref0);
    capture(8'h03, cap1);
    for (int i = 0; i < 4; i++)
      chk8("data_out", ~ref0[8 * i +: 8], cap1[8 * i +: 8]);
    test_done();
  end
endmodule
